/* bench/t1_code_sender.sv */
// remote t1 terminal model sending a repeating in-band code
`timescale 1ns/1ps
module t1_code_sender #(
  parameter int HALF_NS = 200
) (
  // code source
  input wire logic send_en,
  input wire logic [15:0] code,
  input wire logic [4:0] code_len,
  input wire logic [1:0] f_mode,
  input wire logic [7:0] err_every,
  // line pins
  output logic line_clk,
  output logic line_data
);
  logic [3:0] pos_r = 4'h0;
  logic [7:0] fcnt_r = 8'h00;
  logic [7:0] ecnt_r = 8'h01;
  logic [6:0] lfsr_r = 7'h5b;
  logic fbit_r = 1'b0;
  logic [3:0] pos_nxt;

  assign pos_nxt = (5'(pos_r) + 5'h01 >= code_len) ? 4'h0 : pos_r + 4'h1;

  // line runs free, as a t1 line does
  initial begin
    line_clk = 1'b0;
    forever #(HALF_NS) line_clk = ~line_clk;
  end

  // bits change on the falling edge; idle traffic is a scrambled filler
  always @(negedge line_clk) begin
    lfsr_r <= {lfsr_r[5:0], lfsr_r[6] ^ lfsr_r[5]};
    fcnt_r <= (fcnt_r == 8'hc0) ? 8'h00 : fcnt_r + 8'h01;
    if (f_mode != 2'h0 && fcnt_r == 8'hc0) begin
      fbit_r <= ~fbit_r;
      line_data <= fbit_r;
      if (f_mode == 2'h2) pos_r <= pos_nxt;
    end else if (send_en) begin
      ecnt_r <= (ecnt_r >= err_every) ? 8'h01 : ecnt_r + 8'h01;
      line_data <= code[4'hf - pos_r] ^ (err_every != 8'h00 && ecnt_r == err_every);
      pos_r <= pos_nxt;
    end else begin
      line_data <= lfsr_r[0];
    end
  end
endmodule

/* bench/tb.sv */
// self-checking bench for the in-band loop-code detector
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb
  import loop_code_pkg::*;
();
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic t1_mode = 1'b1;
  cpu_pins_s cpu = CPU_PINS_IDLE;
  logic [7:0] data_out;
  logic data_oe;
  wire logic [2:0] st;
  logic line_clk;
  logic line_data;
  logic send_en = 1'b0;
  logic [15:0] code = 16'h0000;
  logic [4:0] code_len = 5'h02;
  logic [1:0] f_mode = 2'h0;
  logic [7:0] err_every = 8'h00;
  int n_errors = 0;
  int compares = 0;
  logic [7:0] hi_off [3] = '{OFF_UP_HIGH, OFF_DOWN_HIGH, OFF_SPARE_HIGH};

  inband_loop_code_detector #(.INTEG_BITS(64)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .t1_mode(t1_mode), .rx_line_clk(line_clk), .rx_line_data(line_data),
    .cs_n(cpu.cs_n), .rd_n(cpu.rd_n), .wr_n(cpu.wr_n), .addr(cpu.addr), .data_in(cpu.wdata),
    .data_out(data_out), .data_oe(data_oe), .loop_activate_detected(st[0]),
    .loop_release_detected(st[1]), .spare_pattern_detected(st[2]));

  t1_code_sender peer (.send_en(send_en), .code(code), .code_len(code_len), .f_mode(f_mode),
    .err_every(err_every), .line_clk(line_clk), .line_data(line_data));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic end_of_test();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic timed_out();
    n_errors++;
    $display("wait timed out at %0t", $time);
    end_of_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu <= '{cs_n: 1'b0, rd_n: 1'b1, wr_n: 1'b0, addr: a, wdata: d};
    tick(6);
    cpu.cs_n <= 1'b1;
    cpu.wr_n <= 1'b1;
    tick(6);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    int i;
    cpu <= '{cs_n: 1'b0, rd_n: 1'b0, wr_n: 1'b1, addr: a, wdata: 8'h00};
    for (i = 0; i < 12 && data_oe !== 1'b1; i++) tick(1);
    if (i == 12) timed_out();
    tick(2);
    `CHK(data_out, e)
    cpu.cs_n <= 1'b1;
    cpu.rd_n <= 1'b1;
    tick(6);
  endtask

  task automatic wait_st(input int k, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && st[k] !== v; i++) tick(1);
    if (i == lim) timed_out();
  endtask

  // program one detector, send its code, then check set, clear and both events
  task automatic run_code(input int k, input logic [2:0] lc, input logic [7:0] hi, input logic [7:0] lo,
                          input logic [1:0] fm, input logic [7:0] ee);
    wr(hi_off[k], hi);
    wr(hi_off[k] + 8'h01, lo);
    if (k == 2) wr(OFF_SPARE_LEN, {5'h00, lc});
    else wr(OFF_LOOP_LEN, (k == 0) ? {2'h0, lc, 3'h6} : {2'h0, 3'h6, lc});
    code = {hi, lo};
    code_len = (lc == 3'h7) ? 5'h10 : 5'(lc) + 5'h02;
    f_mode = fm;
    err_every = ee;
    send_en = 1'b1;
    wait_st(k, 1'b1, 9000);
    tick(400);
    `CHK(st, 3'h1 << k)
    chk_rd(OFF_RT_STATUS, 8'h01 << k);
    chk_rd(OFF_LATCHED, 8'h01 << k);
    wr(OFF_LATCHED, 8'h3f ^ (8'h01 << k));
    chk_rd(OFF_LATCHED, 8'h01 << k);
    wr(OFF_LATCHED, 8'h01 << k);
    chk_rd(OFF_LATCHED, 8'h00);
    send_en = 1'b0;
    f_mode = 2'h0;
    wait_st(k, 1'b0, 3000);
    chk_rd(OFF_LATCHED, 8'h08 << k);
    wr(OFF_LATCHED, 8'h3f);
  endtask

  task automatic sc_regs();
    logic [7:0] v;
    for (int a = 0; a < 10; a++) chk_rd(8'(a), REG_RESET);
    for (int a = 0; a < 8; a++) begin
      v = (a == 0) ? 8'h2b : ((a == 5) ? 8'h03 : 8'h96 ^ 8'(a));
      wr(8'(a), v);
      chk_rd(8'(a), v);
      wr(8'(a), (a == 0) ? 8'h36 : ((a == 5) ? 8'h06 : 8'hff));
    end
    wr(OFF_RT_STATUS, 8'h07);
    chk_rd(OFF_RT_STATUS, 8'h00);
    wr(8'h0d, 8'h5a);
    chk_rd(8'h0d, 8'h00);
  endtask

  task automatic sc_lengths();
    for (int c = 0; c < 8; c++) begin
      run_code(2, 3'(c), 8'h80, (c == 6) ? 8'h80 : ((c == 7) ? 8'h00 : 8'h7f), 2'h0, 8'h00);
    end
  endtask

  // restarts closer together than one window must keep the detector quiet
  task automatic sc_restart(input logic [7:0] a, input logic [7:0] v);
    code = 16'h3c3c;
    code_len = 5'h08;
    send_en = 1'b1;
    for (int n = 0; n < 6; n++) begin
      wr(a, v);
      tick(350);
      `CHK(st[0], 1'b0)
    end
    wait_st(0, 1'b1, 6000);
    send_en = 1'b0;
    wait_st(0, 1'b0, 3000);
    wr(OFF_LATCHED, 8'h3f);
  endtask

  task automatic sc_t1();
    code = 16'h3c3c;
    code_len = 5'h08;
    send_en = 1'b1;
    wait_st(0, 1'b1, 6000);
    t1_mode = 1'b0;
    wait_st(0, 1'b0, 4);
    tick(1500);
    `CHK(st, 3'h0)
    chk_rd(OFF_LATCHED, 8'h09);
    send_en = 1'b0;
    t1_mode = 1'b1;
    wr(OFF_LATCHED, 8'h3f);
  endtask

  initial begin
    tick(8);
    reset_n <= 1'b1;
    tick(10);
    `CHK(st, STATUS_RESET)
    sc_regs();
    run_code(0, 3'h6, 8'h3c, 8'h3c, 2'h1, 8'h00);
    run_code(1, 3'h7, 8'hd2, 8'h4b, 2'h2, 8'h64);
    sc_lengths();
    sc_restart(OFF_UP_LOW, 8'h3c);
    sc_restart(OFF_LOOP_LEN, 8'h36);
    sc_t1();
    end_of_test();
  end
endmodule

/* rtl/inband_loop_code_detector.sv */
// in-band loop-up, loop-down and spare pattern detector with its register port
//
// Function
// [R1] Detection only works in T1 mode.
// [R2] Three detectors: activate, release and spare.
// [R3] Pattern lengths 1 to 8 and 16; the length codes give 2 to 8 and 16 only.
// [R4] Sixteen-bit length joins both code bytes.
// [R5] Software loads equal bytes for 8-bit codes.
// [R6] Short codes ignore the second code byte.
// [R7] Framed or unframed, tolerating one-percent errors; the code accepts up to INTEG_BITS / 4 errors per window.
// [R8] Handles inserted or overwritten framing bits.
// [R9] Low code byte write restarts integration.
// [R10] Length register write restarts its detectors.
// [R11] Detect bit sets after about 36 ms.
// [R12] Real-time plus latched set and clear events.
// [R13] Release length bits 0-2, activate 3-5.
// [R14] Spare length in bits 0 to 2.
// [R15] Software writes zero to spare bits 3-7.
// [R16] Bit 7 is the first pattern bit.
// [R17] Software polls status for five seconds.
// [R18] Writing one clears latched bits only.
// [R19] Fixed mapping of length codes to lengths.
// [R20] Detect bit clears after a bad window.
// [R21] Comparison advances once per received bit.
`timescale 1ns/1ps
module inband_loop_code_detector
  import loop_code_pkg::*;
#(
  parameter int INTEG_BITS = INTEG_BITS_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // framer mode
  input wire logic t1_mode,
  // receive line
  input wire logic rx_line_clk,
  input wire logic rx_line_data,
  // parallel register port
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // status levels
  output logic loop_activate_detected,
  output logic loop_release_detected,
  output logic spare_pattern_detected
);
  logic [1:0] rst_sync_r;
  logic rst_n;

  cpu_pins_s pins_raw;
  cpu_pins_s pins;
  logic [1:0] line_lvl;
  logic line_clk_d_r;
  logic bit_valid;

  logic wr_act;
  logic wr_act_d_r;
  logic wr_pulse;
  logic rd_act;

  logic [7:0] loop_code_length_ctrl_r;
  logic [7:0] up_code_pattern_high_r;
  logic [7:0] up_code_pattern_low_r;
  logic [7:0] down_code_pattern_high_r;
  logic [7:0] down_code_pattern_low_r;
  logic [7:0] spare_code_length_ctrl_r;
  logic [7:0] spare_code_pattern_high_r;
  logic [7:0] spare_code_pattern_low_r;

  logic [2:0] release_code_length;
  logic [2:0] activate_code_length;
  logic [2:0] spare_code_length;

  pattern_cfg_s cfg [NUM_DET];
  logic [NUM_DET-1:0] restart;
  logic [NUM_DET-1:0] det_present;
  logic [2:0] pattern_realtime_status;
  logic [2:0] rt_d_r;
  logic [2:0] rise_evt;
  logic [2:0] fall_evt;
  logic [5:0] pattern_latched_status;
  logic [5:0] latched_clr;
  logic [7:0] rdata_nxt;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // pin synchronisers
  assign pins_raw = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, addr: addr, wdata: data_in};

  pin_filter_sync #(
    .WIDTH($bits(cpu_pins_s)),
    .RESET_VAL(CPU_PINS_IDLE)
  ) u_cpu_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(pins_raw),
    .level_out(pins)
  );

  pin_filter_sync #(
    .WIDTH(2),
    .RESET_VAL(2'b00)
  ) u_line_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .pin_in({rx_line_clk, rx_line_data}),
    .level_out(line_lvl)
  );

  // one bit per rising edge of the line clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_clk_d_r <= 1'b0;
    end else begin
      line_clk_d_r <= line_lvl[1];
    end
  end
  assign bit_valid = line_lvl[1] && !line_clk_d_r; // see [R21]

  // port strobes
  assign wr_act = !pins.cs_n && !pins.wr_n;
  assign rd_act = !pins.cs_n && !pins.rd_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_act_d_r <= 1'b0;
    end else begin
      wr_act_d_r <= wr_act;
    end
  end
  assign wr_pulse = wr_act && !wr_act_d_r;

  // configuration registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_code_length_ctrl_r <= REG_RESET;
      up_code_pattern_high_r <= REG_RESET;
      up_code_pattern_low_r <= REG_RESET;
      down_code_pattern_high_r <= REG_RESET;
      down_code_pattern_low_r <= REG_RESET;
      spare_code_length_ctrl_r <= REG_RESET;
      spare_code_pattern_high_r <= REG_RESET;
      spare_code_pattern_low_r <= REG_RESET;
    end else if (wr_pulse) begin
      unique case (pins.addr)
        OFF_LOOP_LEN: loop_code_length_ctrl_r <= pins.wdata;
        OFF_UP_HIGH: up_code_pattern_high_r <= pins.wdata;
        OFF_UP_LOW: up_code_pattern_low_r <= pins.wdata;
        OFF_DOWN_HIGH: down_code_pattern_high_r <= pins.wdata;
        OFF_DOWN_LOW: down_code_pattern_low_r <= pins.wdata;
        OFF_SPARE_LEN: spare_code_length_ctrl_r <= pins.wdata; // see [R15]
        OFF_SPARE_HIGH: spare_code_pattern_high_r <= pins.wdata;
        OFF_SPARE_LOW: spare_code_pattern_low_r <= pins.wdata;
        default: ;
      endcase
    end
  end

  // length fields
  assign release_code_length = loop_code_length_ctrl_r[RELEASE_LEN_LSB +: 3]; // see [R13]
  assign activate_code_length = loop_code_length_ctrl_r[ACTIVATE_LEN_LSB +: 3]; // see [R13]
  assign spare_code_length = spare_code_length_ctrl_r[SPARE_LEN_LSB +: 3]; // see [R14]

  // equal bytes for 8-bit codes are software's job; only the high byte is used then
  assign cfg[DET_UP] = '{len_code: activate_code_length, high: up_code_pattern_high_r,
                         low: up_code_pattern_low_r}; // see [R5]
  assign cfg[DET_DOWN] = '{len_code: release_code_length, high: down_code_pattern_high_r,
                           low: down_code_pattern_low_r};
  assign cfg[DET_SPARE] = '{len_code: spare_code_length, high: spare_code_pattern_high_r,
                            low: spare_code_pattern_low_r};

  // integration restarts on low byte or length writes
  assign restart[DET_UP] = wr_pulse && (pins.addr == OFF_UP_LOW || pins.addr == OFF_LOOP_LEN); // see [R9] see [R10]
  assign restart[DET_DOWN] = wr_pulse && (pins.addr == OFF_DOWN_LOW || pins.addr == OFF_LOOP_LEN); // see [R9] see [R10]
  assign restart[DET_SPARE] = wr_pulse && (pins.addr == OFF_SPARE_LOW || pins.addr == OFF_SPARE_LEN); // see [R9] see [R10]

  // three independent detectors
  for (genvar d = 0; d < NUM_DET; d++) begin : g_det // see [R2]
    loop_pattern_matcher #(
      .INTEG_BITS(INTEG_BITS)
    ) u_matcher (
      .clk(ref_clk),
      .rst_n(rst_n),
      .enable(t1_mode), // see [R1]
      .restart(restart[d]),
      .cfg(cfg[d]),
      .bit_valid(bit_valid),
      .bit_data(line_lvl[0]),
      .present(det_present[d])
    );
  end

  assign pattern_realtime_status = det_present; // see [R12]
  assign loop_activate_detected = det_present[DET_UP];
  assign loop_release_detected = det_present[DET_DOWN];
  assign spare_pattern_detected = det_present[DET_SPARE];

  // edge detection of real-time status
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rt_d_r <= STATUS_RESET;
    end else begin
      rt_d_r <= pattern_realtime_status;
    end
  end
  assign rise_evt = pattern_realtime_status & ~rt_d_r; // see [R11]
  assign fall_evt = ~pattern_realtime_status & rt_d_r; // see [R20]

  // latched events, write one to clear, a new event wins over the clear
  assign latched_clr = (wr_pulse && pins.addr == OFF_LATCHED) ? pins.wdata[5:0] : 6'h00;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pattern_latched_status <= LATCHED_RESET;
    end else begin
      pattern_latched_status <= (pattern_latched_status & ~latched_clr)
                                | {fall_evt, rise_evt}; // see [R12] see [R18]
    end
  end

  // read data
  always_comb begin
    unique case (pins.addr)
      OFF_LOOP_LEN: rdata_nxt = loop_code_length_ctrl_r;
      OFF_UP_HIGH: rdata_nxt = up_code_pattern_high_r;
      OFF_UP_LOW: rdata_nxt = up_code_pattern_low_r;
      OFF_DOWN_HIGH: rdata_nxt = down_code_pattern_high_r;
      OFF_DOWN_LOW: rdata_nxt = down_code_pattern_low_r;
      OFF_SPARE_LEN: rdata_nxt = spare_code_length_ctrl_r;
      OFF_SPARE_HIGH: rdata_nxt = spare_code_pattern_high_r;
      OFF_SPARE_LOW: rdata_nxt = spare_code_pattern_low_r;
      OFF_RT_STATUS: rdata_nxt = {5'h00, pattern_realtime_status};
      OFF_LATCHED: rdata_nxt = {2'b00, pattern_latched_status};
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 8'h00;
    end else begin
      data_out <= rdata_nxt;
    end
  end
  assign data_oe = rd_act;

  AST_NOT_T1_CLEARS: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R1]
    !t1_mode |=> pattern_realtime_status == 3'h0)
    else $error("detect status set outside T1 mode");

  AST_SET_EVENT_LATCHES: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R12]
    $rose(loop_activate_detected) |=> pattern_latched_status[SET_EVT_LSB + DET_UP])
    else $error("activate set event not latched");

  AST_CLEAR_EVENT_LATCHES: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R20]
    $fell(spare_pattern_detected) |=> pattern_latched_status[CLR_EVT_LSB + DET_SPARE])
    else $error("spare clear event not latched");

  AST_W1C_CLEARS: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R18]
    (wr_pulse && pins.addr == OFF_LATCHED && pins.wdata[0] && !rise_evt[0])
      |=> !pattern_latched_status[0])
    else $error("write one did not clear latched bit");

  AST_W0_KEEPS: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R18]
    (wr_pulse && pins.addr == OFF_LATCHED && !pins.wdata[1] && pattern_latched_status[1])
      |=> pattern_latched_status[1])
    else $error("write zero disturbed a latched bit");

  AST_LOW_WRITE_RESTARTS: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R9]
    (wr_pulse && pins.addr == OFF_DOWN_LOW) |-> restart == 3'b010)
    else $error("low byte write restarted the wrong detector");

  AST_LEN_WRITE_RESTARTS: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R10]
    (wr_pulse && pins.addr == OFF_LOOP_LEN) |-> restart == 3'b011)
    else $error("length write restart mismatch");

  AST_RT_READ: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R12]
    (pins.addr == OFF_RT_STATUS) ##1 (pins.addr == OFF_RT_STATUS)
      |-> data_out == {5'h00, $past(pattern_realtime_status)})
    else $error("real-time status read wrong");

  AST_UP_LOW_RESTARTS: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R9]
    (wr_pulse && pins.addr == OFF_UP_LOW) |-> restart == 3'b001)
    else $error("up low byte write restarted the wrong detector");

  AST_HIGH_WRITE_KEEPS: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R9]
    (wr_pulse && pins.addr == OFF_UP_HIGH) |-> restart == 3'b000)
    else $error("high byte write restarted a detector");

  AST_SPARE_LEN_RESTARTS: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R10]
    (wr_pulse && pins.addr == OFF_SPARE_LEN) |-> restart == 3'b100)
    else $error("spare length write restart mismatch");

  AST_DOWN_SET_LATCHES: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R12]
    $rose(loop_release_detected) |=> pattern_latched_status[SET_EVT_LSB + DET_DOWN])
    else $error("release set event not latched");

  AST_SPARE_SET_LATCHES: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R12]
    $rose(spare_pattern_detected) |=> pattern_latched_status[SET_EVT_LSB + DET_SPARE])
    else $error("spare set event not latched");

  AST_UP_CLEAR_LATCHES: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R20]
    $fell(loop_activate_detected) |=> pattern_latched_status[CLR_EVT_LSB + DET_UP])
    else $error("activate clear event not latched");

  AST_DOWN_CLEAR_LATCHES: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R20]
    $fell(loop_release_detected) |=> pattern_latched_status[CLR_EVT_LSB + DET_DOWN])
    else $error("release clear event not latched");

  AST_LATCH_HOLDS: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R18]
    (pattern_latched_status[3] && !(wr_pulse && pins.addr == OFF_LATCHED)) |=> pattern_latched_status[3])
    else $error("latched bit lost without a clear");

  AST_UNMAPPED_READ_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R12]
    (pins.addr > OFF_LATCHED) |=> data_out == 8'h00)
    else $error("unmapped offset read not zero");
endmodule

/* rtl/loop_code_pkg.sv */
// shared constants, types and helpers for the in-band loop-code detector
package loop_code_pkg;

  // register offsets on the 8-bit parallel port
  localparam logic [7:0] OFF_LOOP_LEN = 8'h00;
  localparam logic [7:0] OFF_UP_HIGH = 8'h01;
  localparam logic [7:0] OFF_UP_LOW = 8'h02;
  localparam logic [7:0] OFF_DOWN_HIGH = 8'h03;
  localparam logic [7:0] OFF_DOWN_LOW = 8'h04;
  localparam logic [7:0] OFF_SPARE_LEN = 8'h05;
  localparam logic [7:0] OFF_SPARE_HIGH = 8'h06;
  localparam logic [7:0] OFF_SPARE_LOW = 8'h07;
  localparam logic [7:0] OFF_RT_STATUS = 8'h08;
  localparam logic [7:0] OFF_LATCHED = 8'h09;

  // field positions
  localparam int RELEASE_LEN_LSB = 0;
  localparam int ACTIVATE_LEN_LSB = 3;
  localparam int SPARE_LEN_LSB = 0;
  localparam int SET_EVT_LSB = 0;
  localparam int CLR_EVT_LSB = 3;

  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [5:0] LATCHED_RESET = 6'h00;

  // detector indices
  localparam int DET_UP = 0;
  localparam int DET_DOWN = 1;
  localparam int DET_SPARE = 2;
  localparam int NUM_DET = 3;

  // timing: integration time in ms and line rate, counted in received bits
  localparam int INTEG_TIME_MS = 36;
  localparam int T1_BIT_RATE_HZ = 1544000;
  localparam int INTEG_BITS_DEF = INTEG_TIME_MS * (T1_BIT_RATE_HZ / 1000);
  localparam int BLOCK_BITS = 16;
  localparam int SLIP_ERRS = 4;
  localparam int ERR_DIVISOR = 4;

  // length field encodings: 0..6 give 2..8 bits, 7 gives 16 bits
  localparam logic [2:0] LEN_CODE_16 = 3'h7;
  localparam logic [4:0] LEN_BASE = 5'h02;
  localparam logic [4:0] LEN_SIXTEEN = 5'h10;

  typedef struct packed {
    logic [2:0] len_code;
    logic [7:0] high;
    logic [7:0] low;
  } pattern_cfg_s;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpu_pins_s;

  localparam cpu_pins_s CPU_PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 8'h00, wdata: 8'h00};

  function automatic logic [4:0] decode_len(input logic [2:0] code);
    decode_len = (code == LEN_CODE_16) ? LEN_SIXTEEN : (LEN_BASE + {2'b00, code});
  endfunction

endpackage

/* rtl/loop_pattern_matcher.sv */
// one repeating-pattern detector with phase hunt and error-tolerant integration
`timescale 1ns/1ps
module loop_pattern_matcher
  import loop_code_pkg::*;
#(
  parameter int INTEG_BITS = INTEG_BITS_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  input wire logic restart,
  input wire pattern_cfg_s cfg,
  // received bits
  input wire logic bit_valid,
  input wire logic bit_data,
  // result
  output logic present
);
  localparam logic [15:0] WIN_LAST = 16'(INTEG_BITS - 1);
  localparam logic [15:0] ERR_LIMIT = 16'(INTEG_BITS / ERR_DIVISOR);
  localparam logic [3:0] BLK_LAST = 4'(BLOCK_BITS - 1);
  localparam logic [4:0] SLIP_LIM = 5'(SLIP_ERRS);

  logic [4:0] len;
  logic [4:0] ptr_r;
  logic [15:0] pat16;
  logic exp_bit;
  logic miss;
  logic [3:0] blk_cnt_r;
  logic [4:0] blk_err_r;
  logic [4:0] blk_err_nxt;
  logic slip;
  logic [15:0] bit_cnt_r;
  logic [15:0] err_cnt_r;
  logic [15:0] err_cnt_nxt;
  logic win_end;

  assign len = decode_len(cfg.len_code); // see [R19]
  assign pat16 = {cfg.high, cfg.low}; // see [R4]
  // short codes take bit 7 first and never look at the low byte
  assign exp_bit = (len == LEN_SIXTEEN) ? pat16[4'(5'd15 - ptr_r)] : cfg.high[3'(5'd7 - ptr_r)]; // see [R6] see [R16]
  assign miss = bit_data != exp_bit;
  assign blk_err_nxt = blk_err_r + {4'h0, miss};
  assign slip = (blk_cnt_r == BLK_LAST) && (blk_err_nxt >= SLIP_LIM); // see [R8]
  assign err_cnt_nxt = err_cnt_r + {15'h0000, miss};
  assign win_end = bit_cnt_r == WIN_LAST;

  // pattern phase: one step per received bit, held a bit on slip to hunt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= 5'h00;
    end else if (restart || !enable) begin
      ptr_r <= 5'h00;
    end else if (bit_valid && !slip) begin // see [R21]
      ptr_r <= (ptr_r >= len - 5'd1) ? 5'h00 : ptr_r + 5'd1; // see [R3]
    end
  end

  // phase-hunt block counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blk_cnt_r <= 4'h0;
      blk_err_r <= 5'h00;
    end else if (restart || !enable) begin
      blk_cnt_r <= 4'h0;
      blk_err_r <= 5'h00;
    end else if (bit_valid) begin
      blk_cnt_r <= blk_cnt_r + 4'd1;
      blk_err_r <= (blk_cnt_r == BLK_LAST) ? 5'h00 : blk_err_nxt;
    end
  end

  // integration window in bits and its error tally
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= 16'h0000;
      err_cnt_r <= 16'h0000;
    end else if (restart || !enable) begin // see [R9] see [R10]
      bit_cnt_r <= 16'h0000;
      err_cnt_r <= 16'h0000;
    end else if (bit_valid) begin
      bit_cnt_r <= win_end ? 16'h0000 : bit_cnt_r + 16'd1;
      err_cnt_r <= win_end ? 16'h0000 : err_cnt_nxt;
    end
  end

  // decision at each window end; a bad window clears presence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      present <= 1'b0;
    end else if (!enable) begin // see [R1]
      present <= 1'b0;
    end else if (bit_valid && win_end && !restart) begin
      present <= err_cnt_nxt <= ERR_LIMIT; // see [R7] see [R11] see [R20]
    end
  end

  AST_PTR_IN_RANGE: assert property (@(posedge clk) disable iff (!rst_n) // see [R3]
    enable |-> ptr_r < len)
    else $error("pattern phase outside the code length");

  AST_RESTART_CLEARS_WINDOW: assert property (@(posedge clk) disable iff (!rst_n) // see [R9]
    restart |=> (bit_cnt_r == 16'h0000) && (err_cnt_r == 16'h0000))
    else $error("restart did not clear the integration window");

  AST_PRESENT_ONLY_AT_WINDOW_END: assert property (@(posedge clk) disable iff (!rst_n) // see [R11]
    $rose(present) |-> $past(bit_valid && win_end && enable))
    else $error("presence rose outside a window end");
endmodule

/* rtl/pin_filter_sync.sv */
// three-flop pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_filter_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins and filtered levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        level_out[i] <= RESET_VAL[i];
      end else if (s2_r[i] == s3_r[i]) begin
        level_out[i] <= s3_r[i];
      end
    end
  end
endmodule
